// ### core/power_mode_and_reset_control.v
// power mode, supply warning, ram power and reset source control
// Summary of operation
// - linear regulator after reset; switching regulator only when its enable is set
// - power-down write removes core power and aborts all ongoing tasks
// - powered down, wake only on pin detect or a reset
// - leaving power-down always goes through a reset (wakeup, pin, debug port, por), never resumes
// - in debug mode power-down is only emulated, everything but the warning comparator stays powered
// - running state after power-on; cause record keeps reset and wakeup causes, sticky until cleared
// - fixed latency task keeps basic resources on for fixed wakeup latency
// - low power task selects variable latency; default on entering running
// - enabled comparator raises warning event on supply drop, no reset
// - event also when enabled while low or threshold raised above supply
// - warning enabled and supply low blocks nonvolatile memory writes
// - comparator inactive in power-down and while high freq clock stopped
// - powered down, ram inaccessible, retained exactly when retention is on
// - running, ram with power on accessible and retained, else per retention
// - power-on reset holds until supply ok and regulators started
// - selected reset pin asserted gives a pin reset
// - soft reset from core reset request or control access port reset
// - watchdog timeout resets except when powered down; brownout holds reset
// - lockup and soft reset cpu, peripherals, pins; wakeup spares debug in debug mode
// - watchdog and pin also reset debug, watchdog, retained; only por/brownout the rest
`timescale 1ns/100ps
`include "pwr_consts.vh"

module power_mode_and_reset_control #(
	parameter N_RAM = 3,
	parameter RST_HOLD = 4
) (
	input wire clk_sys,
	input wire rst,
	input wire [11:0] addr,
	input wire [31:0] wdata,
	input wire wr,
	input wire rd,
	output reg [31:0] rdata,
	input wire supply_ok,
	input wire regulators_ready,
	input wire brownout_low,
	input wire [31:0] gpio_level,
	input wire pin_detect,
	input wire core_system_reset_request,
	input wire cap_reset_write,
	input wire lockup,
	input wire watchdog_timeout,
	input wire debug_mode,
	input wire high_freq_clock_running,
	input wire supply_below,
	output wire switching_regulator_enable,
	output wire core_power_off,
	output reg abort_tasks,
	output wire fixed_latency_active,
	output wire [3:0] supply_warning_threshold,
	output wire supply_warning_comparator_on,
	output reg supply_warning_event,
	output wire nvm_write_block,
	output wire [N_RAM-1:0] ram_access,
	output wire [N_RAM-1:0] ram_retain,
	output wire rst_cpu,
	output wire rst_periph,
	output wire rst_pins,
	output wire rst_debug,
	output wire rst_serial_dp,
	output wire rst_watchdog,
	output wire rst_retained
);

	// ram control register slot for an address, -1 when none
	function integer ram_sel;
		input [11:0] a;
		begin
			ram_sel = -1;
			if (a >= `OFS_RAM_BASE &&
				a < `OFS_RAM_BASE + (N_RAM << `RAM_STRIDE_SH))
				ram_sel = (a - `OFS_RAM_BASE) >> `RAM_STRIDE_SH;
		end
	endfunction

	// a pin select register asserts reset when connected and its pin is low
	function pin_low;
		input [31:0] sel;
		input [31:0] lvl;
		begin
			pin_low = ~sel[`PINSEL_DIS_BIT] & ~lvl[sel[`PINSEL_PIN_MSB:0]];
		end
	endfunction

	// state and register bank
	reg [1:0] state_q;
	reg fixed_lat_q;
	reg swreg_q;
	reg [4:0] cfg_q;
	reg evt_q;
	reg warn_prev_q;
	reg [31:0] cause_q;
	reg [31:0] pinsel0_q;
	reg [31:0] pinsel1_q;
	reg [`RETAIN_W-1:0] retain0_q;
	reg [`RETAIN_W-1:0] retain1_q;
	reg [N_RAM-1:0] ram_pwr_q;
	reg [N_RAM-1:0] ram_ret_q;
	reg [3:0] pend_q;
	reg [3:0] pend_d;
	reg [7:0] hold_q;
	reg [7:0] hold_d;
	reg [6:0] tgt_q;
	reg [6:0] tgt_d;
	reg [31:0] rdata_d;
	integer i;
	integer j;

	// ram control slot of the current address, shared by the write and read paths
	wire signed [31:0] ram_slot = ram_sel(addr);

	wire st_run = (state_q == `ST_RUN);
	wire st_off = (state_q == `ST_OFF);
	wire st_down = (state_q != `ST_RUN);

	wire por_src = rst | ~supply_ok | ~regulators_ready;
	wire bor_src = brownout_low;
	// a reset pin stays effective in every power state
	wire pin_src = pin_low(pinsel0_q, gpio_level) | pin_low(pinsel1_q, gpio_level);
	wire wdt_fire = watchdog_timeout & ~st_off;
	wire lock_fire = lockup & ~debug_mode & ~st_off;
	// the debug port reset is honoured even powered down; the core request needs a running core
	wire soft_fire = (core_system_reset_request & ~st_off) | cap_reset_write;
	// wake works from real and emulated power-down alike
	wire wake_fire = st_down & pin_detect;
	// pending order: watchdog, wakeup, soft, lockup
	wire [3:0] fire = {wdt_fire, wake_fire, soft_fire, lock_fire};
	wire [3:0] pend_now = pend_q | fire;

	wire pd_write = wr & (addr == `OFS_PDOWN) & wdata[`TRIG_BIT];

	// pulse sources are stretched so every target sees a reset of known length
	always @* begin
		pend_d = pend_q;
		hold_d = hold_q;
		if (|fire) begin
			pend_d = pend_now;
			hold_d = RST_HOLD[7:0] - 8'h01;
		end else if (hold_q != 8'h00) begin
			hold_d = hold_q - 8'h01;
		end else begin
			pend_d = 4'h0;
		end
	end

	// each active source contributes its whole target set at once
	always @* begin
		tgt_d = `MASK_NONE;
		// por and brownout reach the serial debug port target, which also clears the cause record
		if (por_src | bor_src)
			tgt_d = tgt_d | `MASK_ALL;
		if (pin_src | pend_now[3])
			tgt_d = tgt_d | `MASK_WDT;
		if (pend_now[2])
			tgt_d = tgt_d | (debug_mode ? `MASK_WAKE_DBG : `MASK_WAKE);
		if (pend_now[1] | pend_now[0])
			tgt_d = tgt_d | `MASK_SOFT;
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			pend_q <= 4'h0;
			hold_q <= 8'h00;
			tgt_q <= `MASK_ALL;
		end else begin
			pend_q <= pend_d;
			hold_q <= hold_d;
			tgt_q <= tgt_d;
		end
	end

	// targets come straight from flip-flops so no decode glitch reaches a reset net
	assign rst_cpu = tgt_q[`T_CPU];
	assign rst_periph = tgt_q[`T_PERIPH];
	assign rst_pins = tgt_q[`T_PINS];
	assign rst_debug = tgt_q[`T_DEBUG];
	assign rst_serial_dp = tgt_q[`T_SDP];
	assign rst_watchdog = tgt_q[`T_WDT];
	assign rst_retained = tgt_q[`T_RETAINED];

	// power state; any peripheral-level reset returns to running
	always @(posedge clk_sys) begin
		if (rst || tgt_d[`T_PERIPH]) begin
			state_q <= `ST_RUN;
			abort_tasks <= 1'b0;
		end else begin
			abort_tasks <= 1'b0;
			case (state_q)
				`ST_RUN: begin
					if (pd_write) begin
						state_q <= debug_mode ? `ST_EMU : `ST_OFF;
						abort_tasks <= 1'b1;
					end
				end
				// leaving is only through a peripheral-level reset above (wakeup, pin, debug port, por), never by resuming
				`ST_OFF: state_q <= `ST_OFF;
				// emulated: clocks, flash and ram stay up so the debugger keeps its hold
				`ST_EMU: state_q <= `ST_EMU;
				default: state_q <= `ST_RUN;
			endcase
		end
	end

	// software must have stopped memory transfers; nothing here waits for them
	assign core_power_off = st_off;

	// sub-mode and plain control registers are cleared with the peripherals
	always @(posedge clk_sys) begin
		if (rst || tgt_d[`T_PERIPH]) begin
			fixed_lat_q <= 1'b0;
			swreg_q <= 1'b0;
			cfg_q <= `CFG_RST;
		end else if (wr) begin
			if (addr == `OFS_TASK_FIXED && wdata[`TRIG_BIT])
				fixed_lat_q <= 1'b1;
			if (addr == `OFS_TASK_LOWP && wdata[`TRIG_BIT])
				fixed_lat_q <= 1'b0;
			if (addr == `OFS_SWREG)
				swreg_q <= wdata[`TRIG_BIT];
			if (addr == `OFS_WARN_CFG)
				cfg_q <= wdata[`CFG_THR_MSB:0];
		end
	end

	assign fixed_latency_active = fixed_lat_q;
	assign switching_regulator_enable = swreg_q;
	assign supply_warning_threshold = cfg_q[`CFG_THR_MSB:`CFG_THR_LSB];

	// comparator only runs with the system up and the fast clock alive, to save power
	assign supply_warning_comparator_on = cfg_q[`CFG_EN_BIT] & st_run &
		high_freq_clock_running;
	wire warn_level = supply_warning_comparator_on & supply_below;
	// an edge catches a drop, enabling while low, and raising the threshold alike
	wire warn_fire = warn_level & ~warn_prev_q;
	assign nvm_write_block = warn_level;

	// event flag: a new warning wins over a clearing write in the same cycle
	always @(posedge clk_sys) begin
		if (rst || tgt_d[`T_PERIPH]) begin
			warn_prev_q <= 1'b0;
			evt_q <= 1'b0;
			supply_warning_event <= 1'b0;
		end else begin
			warn_prev_q <= warn_level;
			supply_warning_event <= warn_fire;
			if (warn_fire)
				evt_q <= 1'b1;
			else if (wr && addr == `OFS_EVT_WARN && !wdata[`TRIG_BIT])
				evt_q <= 1'b0;
		end
	end

	// cause bits are sticky; a new cause wins over a clearing write
	always @(posedge clk_sys) begin
		if (rst || tgt_d[`T_SDP]) begin
			cause_q <= 32'h00000000;
		end else begin
			if (wr && addr == `OFS_CAUSE)
				cause_q <= cause_q & ~wdata;
			if (pin_src)
				cause_q[`CAUSE_PIN] <= 1'b1;
			if (wdt_fire)
				cause_q[`CAUSE_WDT] <= 1'b1;
			if (soft_fire)
				cause_q[`CAUSE_SOFT] <= 1'b1;
			if (lock_fire)
				cause_q[`CAUSE_LOCK] <= 1'b1;
			if (wake_fire)
				cause_q[`CAUSE_WAKE] <= 1'b1;
		end
	end

	// pin selection is only cleared by por or brownout: clearing it with the
	// retained registers would end a pin reset while the pin is still held low
	always @(posedge clk_sys) begin
		if (rst || tgt_d[`T_SDP]) begin
			pinsel0_q <= `PINSEL_RST;
			pinsel1_q <= `PINSEL_RST;
		end else if (wr) begin
			if (addr == `OFS_PINSEL0)
				pinsel0_q <= wdata;
			if (addr == `OFS_PINSEL1)
				pinsel1_q <= wdata;
		end
	end

	// retained registers survive power-down, soft, lockup and wakeup resets
	always @(posedge clk_sys) begin
		if (rst || tgt_d[`T_RETAINED]) begin
			retain0_q <= {`RETAIN_W{1'b0}};
			retain1_q <= {`RETAIN_W{1'b0}};
			ram_pwr_q <= {N_RAM{`RAM_PWR_RST}};
			ram_ret_q <= {N_RAM{`RAM_RET_RST}};
		end else if (wr) begin
			if (addr == `OFS_RETAIN0)
				retain0_q <= wdata[`RETAIN_W-1:0];
			if (addr == `OFS_RETAIN1)
				retain1_q <= wdata[`RETAIN_W-1:0];
			for (i = 0; i < N_RAM; i = i + 1) begin
				if (ram_slot == i) begin
					case (addr[3:0])
						`RAM_SUB_PWR: begin
							ram_pwr_q[i] <= wdata[`RAM_PWR_BIT];
							ram_ret_q[i] <= wdata[`RAM_RET_BIT];
						end
						`RAM_SUB_SET: begin
							if (wdata[`RAM_PWR_BIT])
								ram_pwr_q[i] <= 1'b1;
							if (wdata[`RAM_RET_BIT])
								ram_ret_q[i] <= 1'b1;
						end
						`RAM_SUB_CLR: begin
							if (wdata[`RAM_PWR_BIT])
								ram_pwr_q[i] <= 1'b0;
							if (wdata[`RAM_RET_BIT])
								ram_ret_q[i] <= 1'b0;
						end
						default: ram_pwr_q[i] <= ram_pwr_q[i];
					endcase
				end
			end
		end
	end

	// ram contents are never cleared here; only power and retention are steered
	// emulated power-down keeps ram powered as in running
	assign ram_access = st_off ? {N_RAM{1'b0}} : ram_pwr_q;
	assign ram_retain = st_off ? ram_ret_q : (ram_pwr_q | ram_ret_q);

	// read data stand only in the cycle after the strobe
	always @* begin
		rdata_d = 32'h00000000;
		case (addr)
			`OFS_EVT_WARN: rdata_d[`TRIG_BIT] = evt_q;
			`OFS_CAUSE: rdata_d = cause_q;
			`OFS_WARN_CFG: rdata_d[`CFG_THR_MSB:0] = cfg_q;
			`OFS_RETAIN0: rdata_d[`RETAIN_W-1:0] = retain0_q;
			`OFS_RETAIN1: rdata_d[`RETAIN_W-1:0] = retain1_q;
			`OFS_SWREG: rdata_d[`TRIG_BIT] = swreg_q;
			`OFS_PINSEL0: rdata_d = pinsel0_q;
			`OFS_PINSEL1: rdata_d = pinsel1_q;
			default: begin
				for (j = 0; j < N_RAM; j = j + 1) begin
					if (ram_slot == j && (addr[3:0] == `RAM_SUB_PWR ||
						addr[3:0] == `RAM_SUB_SET || addr[3:0] == `RAM_SUB_CLR)) begin
						rdata_d[`RAM_PWR_BIT] = ram_pwr_q[j];
						rdata_d[`RAM_RET_BIT] = ram_ret_q[j];
					end
				end
			end
		endcase
	end

	// outside a read the port returns zero, so stale data never looks valid
	always @(posedge clk_sys) begin
		if (rst)
			rdata <= 32'h00000000;
		else if (rd)
			rdata <= rdata_d;
		else
			rdata <= 32'h00000000;
	end

endmodule // power_mode_and_reset_control

// ### core/pwr_consts.vh
// offsets, field positions, reset values and codes for the power and reset control block
`ifndef PWR_CONSTS_VH
`define PWR_CONSTS_VH
`define OFS_TASK_FIXED 12'h078
`define OFS_TASK_LOWP 12'h07c
`define OFS_EVT_WARN 12'h108
`define OFS_CAUSE 12'h400
`define OFS_PDOWN 12'h500
`define OFS_WARN_CFG 12'h510
`define OFS_RETAIN0 12'h51c
`define OFS_RETAIN1 12'h520
`define OFS_SWREG 12'h578
`define OFS_PINSEL0 12'h200
`define OFS_PINSEL1 12'h204
`define OFS_RAM_BASE 12'h900
`define RAM_STRIDE_SH 4
`define RAM_SUB_PWR 4'h0
`define RAM_SUB_SET 4'h4
`define RAM_SUB_CLR 4'h8
`define RAM_PWR_BIT 0
`define RAM_RET_BIT 16
`define RAM_PWR_RST 1'b1
`define RAM_RET_RST 1'b0
`define TRIG_BIT 0
`define CFG_EN_BIT 0
`define CFG_THR_LSB 1
`define CFG_THR_MSB 4
`define CFG_RST 5'h00
`define PINSEL_PIN_MSB 4
`define PINSEL_DIS_BIT 31
`define PINSEL_RST 32'hffffffff
`define RETAIN_W 8
`define CAUSE_PIN 0
`define CAUSE_WDT 1
`define CAUSE_SOFT 2
`define CAUSE_LOCK 3
`define CAUSE_WAKE 16
`define T_CPU 0
`define T_PERIPH 1
`define T_PINS 2
`define T_DEBUG 3
`define T_SDP 4
`define T_WDT 5
`define T_RETAINED 6
`define MASK_NONE 7'h00
`define MASK_SOFT 7'h07
`define MASK_WAKE 7'h0b
`define MASK_WAKE_DBG 7'h03
`define MASK_WDT 7'h6f
`define MASK_ALL 7'h7f
`define ST_RUN 2'h0
`define ST_OFF 2'h1
`define ST_EMU 2'h2
`endif

// ### tb/power_mode_and_reset_control_tb.sv
// self-checking bench for the power mode and reset control block
`timescale 1ns/100ps
`include "pwr_consts.vh"
module power_mode_and_reset_control_tb;
	logic clk_sys = 0, rst = 1, wr = 0, rd = 0, supply_ok = 1, regulators_ready = 1;
	logic brownout_low = 0, pin_detect = 0, core_system_reset_request = 0;
	logic cap_reset_write = 0, lockup = 0, watchdog_timeout = 0, debug_mode = 0;
	logic high_freq_clock_running = 1, supply_below = 0;
	logic [11:0] addr = '0;
	logic [31:0] wdata = '0, gpio_level = '1, rdata;
	logic switching_regulator_enable, core_power_off, abort_tasks, fixed_latency_active;
	logic [3:0] supply_warning_threshold;
	logic supply_warning_comparator_on, supply_warning_event, nvm_write_block;
	logic [2:0] ram_access, ram_retain;
	logic rst_cpu, rst_periph, rst_pins, rst_debug, rst_serial_dp, rst_watchdog, rst_retained;
	wire [6:0] rv = {rst_retained, rst_watchdog, rst_serial_dp, rst_debug, rst_pins,
		rst_periph, rst_cpu};
	int fails = 0, compares = 0;
	always #5 clk_sys = ~clk_sys;
	power_mode_and_reset_control #(.N_RAM(3), .RST_HOLD(4)) dut (.*);
	task automatic results();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1;
		@(posedge clk_sys);
		wr <= 0;
		#1;
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1;
		@(posedge clk_sys);
		rd <= 0;
		#1 chk(rdata, e, "read");
	endtask
	// bounded wait for the targets to drop; a hang ends the run
	task automatic wait_rel();
		for (int i = 0; i < 50 && rst_cpu !== 1'b0; i++)
			@(posedge clk_sys);
		if (rst_cpu !== 1'b0) begin
			fails++;
			$display("ERROR %0t reset stuck", $time);
			results();
		end
		#1;
	endtask
	task automatic pulse(input int s, input logic [6:0] m);
		@(posedge clk_sys);
		case (s)
			0: core_system_reset_request <= 1;
			1: cap_reset_write <= 1;
			2: lockup <= 1;
			3: watchdog_timeout <= 1;
			default: pin_detect <= 1;
		endcase
		@(posedge clk_sys);
		{core_system_reset_request, cap_reset_write, lockup, watchdog_timeout, pin_detect} <= '0;
		#1 chk(rv, m, "targets");
		wait_rel();
	endtask
	// causes expected from core request, access port, lockup and watchdog
	logic [31:0] cause [4] = '{32'h4, 32'h4, 32'h8, 32'h2};
	initial begin
		repeat (16) @(posedge clk_sys);
		rst <= 0;
		wait_rel();
		chk(switching_regulator_enable, 0, "linear");
		chk(fixed_latency_active, 0, "sub mode");
		chk(ram_access, 3'h7, "ram on");
		rd_chk(`OFS_CAUSE, 0);
		rd_chk(`OFS_RAM_BASE, 1);
		rd_chk(12'h004, 0);
		$display("reset values done");
		wr_reg(`OFS_SWREG, 1);
		chk(switching_regulator_enable, 1, "switching");
		wr_reg(`OFS_TASK_FIXED, 1);
		chk(fixed_latency_active, 1, "fixed");
		wr_reg(`OFS_TASK_LOWP, 1);
		chk(fixed_latency_active, 0, "lowp");
		wr_reg(12'h928, 1);
		wr_reg(12'h924, 32'h10000);
		wr_reg(12'h908, 1);
		chk(ram_access, 3'h2, "access");
		chk(ram_retain, 3'h6, "retain");
		wr_reg(12'h910, 32'h10000);
		rd_chk(12'h910, 32'h10000);
		chk(ram_access, 3'h0, "all off");
		chk(ram_retain, 3'h6, "retain off");
		$display("modes and ram done");
		@(posedge clk_sys) supply_below <= 1;
		wr_reg(`OFS_WARN_CFG, 32'h0b);
		chk(nvm_write_block, 1, "nvm");
		chk(supply_warning_threshold, 5, "thr");
		@(posedge clk_sys) #1 chk(supply_warning_event, 1, "enable low");
		rd_chk(`OFS_EVT_WARN, 1);
		wr_reg(`OFS_EVT_WARN, 0);
		rd_chk(`OFS_EVT_WARN, 0);
		@(posedge clk_sys) high_freq_clock_running <= 0;
		@(posedge clk_sys) supply_below <= 0;
		#1 chk(supply_warning_comparator_on, 0, "hf off");
		@(posedge clk_sys) high_freq_clock_running <= 1;
		@(posedge clk_sys) supply_below <= 1;
		@(posedge clk_sys) #1 chk(supply_warning_event, 1, "drop");
		chk(rst_cpu, 0, "no reset");
		$display("warning done");
		wr_reg(`OFS_RETAIN0, 32'h5a);
		for (int s = 0; s < 4; s++) begin
			pulse(s, s == 3 ? `MASK_WDT : `MASK_SOFT);
			rd_chk(`OFS_CAUSE, cause[s]);
			wr_reg(`OFS_CAUSE, cause[s]);
			rd_chk(`OFS_RETAIN0, s == 3 ? 32'h0 : 32'h5a);
		end
		@(posedge clk_sys) debug_mode <= 1;
		pulse(2, `MASK_NONE);
		@(posedge clk_sys) debug_mode <= 0;
		wr_reg(`OFS_PINSEL0, 32'h3);
		@(posedge clk_sys) gpio_level[3] <= 0;
		@(posedge clk_sys) #1 chk(rv, `MASK_WDT, "pin");
		@(posedge clk_sys) gpio_level[3] <= 1;
		wait_rel();
		rd_chk(`OFS_CAUSE, 1);
		wr_reg(`OFS_CAUSE, 1);
		$display("reset sources done");
		wr_reg(12'h904, 32'h10000);
		// no peripheral memory transfer is in flight when power-down is asked for
		wr_reg(`OFS_PDOWN, 1);
		chk(abort_tasks, 1, "abort");
		chk(core_power_off, 1, "off");
		chk(ram_access, 0, "ram off");
		chk(ram_retain, 3'h1, "ram ret");
		pulse(3, `MASK_NONE);
		pulse(0, `MASK_NONE);
		chk(core_power_off, 1, "still off");
		pulse(4, `MASK_WAKE);
		chk(core_power_off, 0, "woken");
		rd_chk(`OFS_CAUSE, 32'h10000);
		@(posedge clk_sys) debug_mode <= 1;
		// software then idles in its loop; only the wake pin moves until the reset
		wr_reg(`OFS_PDOWN, 1);
		chk(abort_tasks, 1, "emu abort");
		chk(core_power_off, 0, "emu");
		pulse(4, `MASK_WAKE_DBG);
		@(posedge clk_sys) debug_mode <= 0;
		$display("power-down done");
		@(posedge clk_sys) regulators_ready <= 0;
		@(posedge clk_sys) #1 chk(rv, `MASK_ALL, "por");
		@(posedge clk_sys) begin
			regulators_ready <= 1;
			brownout_low <= 1;
		end
		@(posedge clk_sys) #1 chk(rv, `MASK_ALL, "brownout");
		@(posedge clk_sys) brownout_low <= 0;
		wait_rel();
		rd_chk(`OFS_CAUSE, 0);
		$display("supply resets done");
		results();
	end
endmodule // power_mode_and_reset_control_tb

// ### tb/pwr_rst_checker_asserts.sv
// port assertions for the power mode and reset control block
`timescale 1ns/100ps
module pwr_rst_checker #(
	parameter N_RAM = 3
) (
	input wire clk_sys,
	input wire rst,
	input wire supply_ok,
	input wire regulators_ready,
	input wire pin_detect,
	input wire core_system_reset_request,
	input wire debug_mode,
	input wire high_freq_clock_running,
	input wire supply_below,
	input wire switching_regulator_enable,
	input wire core_power_off,
	input wire abort_tasks,
	input wire supply_warning_comparator_on,
	input wire supply_warning_event,
	input wire nvm_write_block,
	input wire [N_RAM-1:0] ram_access,
	input wire [N_RAM-1:0] ram_retain,
	input wire rst_cpu,
	input wire rst_periph,
	input wire rst_pins,
	input wire rst_serial_dp
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_reg_linear: assert property ($fell(rst) |-> !switching_regulator_enable)
		else $error("regulator not linear after reset");
	a_pdown_abort: assert property ($rose(core_power_off) |-> abort_tasks)
		else $error("power-down without abort");
	a_emu_on: assert property (abort_tasks && debug_mode |-> !core_power_off)
		else $error("real power-down in debug mode");
	a_wake_reset: assert property (core_power_off && pin_detect
		|=> rst_cpu && rst_periph && !core_power_off) else $error("no wakeup reset");
	a_warn_event: assert property ($rose(supply_warning_comparator_on && supply_below)
		|=> supply_warning_event) else $error("warning event missing");
	a_nvm_block: assert property (nvm_write_block ==
		(supply_warning_comparator_on && supply_below)) else $error("nvm block wrong");
	a_comp_off: assert property (core_power_off || !high_freq_clock_running
		|-> !supply_warning_comparator_on) else $error("comparator active");
	a_ram_off: assert property (core_power_off |-> ram_access == '0)
		else $error("ram accessible when off");
	a_ram_retain: assert property ((ram_access & ~ram_retain) == '0)
		else $error("accessible ram not retained");
	// a taken soft request keeps its targets for the first four cycles of its five-cycle hold window
	a_soft_hold: assert property (!core_power_off && core_system_reset_request
		|=> (rst_cpu && rst_pins)[*4]) else $error("soft reset too short");
	a_por_hold: assert property (!(supply_ok && regulators_ready)
		|=> rst_serial_dp && rst_cpu) else $error("power-on reset not held");
	a_targets_same: assert property (rst_cpu == rst_periph)
		else $error("cpu and peripheral resets apart");
endmodule // pwr_rst_checker
bind power_mode_and_reset_control pwr_rst_checker #(.N_RAM(N_RAM)) chk_i (.*);
